// *** verilog/dac_ctl_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the dual channel converter control.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef DAC_CTL_CONSTS_SVH
`define DAC_CTL_CONSTS_SVH
`define ADDR_CTRL_A 12'h000
`define ADDR_CTRL_B 12'h004
`define ADDR_EVENT_CTRL 12'h00c
`define ADDR_STATUS 12'h014
`define ADDR_CH0_DATA 12'h018
`define ADDR_CH1_DATA 12'h01c
`define ADDR_OFFSET_TRIM 12'h020
`define ADDR_SLOPE_TRIM 12'h024
`define CTRL_A_RESET 8'h00
`define CTRL_A_MASK 8'h1f
`define CTRL_B_MASK 8'h63
`define EVENT_CTRL_MASK 8'h0f
`define DATA_MASK 16'h0fff
`define CLK_PERIOD_NS 20
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_CH0 2'h0
`define SEL_CH1 2'h1
`define SEL_DUAL 2'h2
`endif

// *** verilog/dac_ctl_pkg.sv ***
// Purpose: Types of the dual channel converter control.
// Assumes: Constants come from the header.
// Notes: None.
package dac_ctl_pkg;
    typedef struct packed {
        logic internal_route_enable;
        logic second_channel_pin_enable;
        logic first_channel_pin_enable;
        logic reduced_power_select;
        logic enable;
    } ctrl_a_t;
    typedef struct packed {
        logic [1:0] channel_selection;
        logic [1:0] event_trigger;
    } ctrl_b_t;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b01,
        CH_BUSY = 2'b10
    } ch_state_t;
    typedef struct packed {
        ch_state_t state;
        logic [11:0] count;
        logic [11:0] sample;
        logic [11:0] held;
        logic updated;
        logic slot_empty;
    } chan_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_resp_t;
    typedef struct packed {
        logic [11:0] value;
        logic [1:0] start;
    } dac_out_t;
endpackage : dac_ctl_pkg

// *** verilog/dac_ctl.sv ***
// Purpose: Register file and conversion sequencing of a two channel 12-bit converter.
// Assumes: Inputs synchronous to i_clk; APB slave with one wait state.
// Notes: Analog trim is applied by the converter; this block only stores the codes.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "dac_ctl_consts.svh"
// Operation
// - Data write starts conversion by default.
// - Event trigger starts only after data update.
// - Two independent 12-bit channels with registers.
// - Reduced power doubles conversion time.
// - All logic on peripheral clock.
// - Offset trim: bit7 sign, magnitude bits.
// - Slope trim: bit7 sign, magnitude bits.
// - Control bits 7:5 read zero.
// - Internal route sends channel 0 inside.
// - Second pin enable drives channel 1.
// - First pin enable unless internal route.
// - DMA writes treated as processor writes.
// - Bit 1 selects reduced power.
// - Bit 0 is master enable.
// - Selection: 00 ch0, 01 ch1, 10 both.
// - Slot empty flag drives DMA request.
module dac_ctl
    import dac_ctl_pkg::*;
#(
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [7:0] i_event,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [11:0] o_ch0_value,
    output logic [11:0] o_ch1_value,
    output logic [1:0] o_conv_busy,
    output logic [1:0] o_dma_request,
    output logic o_ch0_pin_enable,
    output logic o_ch1_pin_enable,
    output logic o_internal_route,
    output logic o_reduced_power,
    output logic [7:0] o_offset_trim_value,
    output logic [7:0] o_slope_trim_value
);
    typedef struct packed {
        ctrl_a_t ctrl_a;
        ctrl_b_t ctrl_b;
        logic [3:0] event_select;
        logic [7:0] offset_trim;
        logic [7:0] slope_trim;
        chan_t [1:0] ch;
        apb_resp_t resp;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Tells whether a channel is included by the current selection.
    function automatic logic chan_selected(input logic [1:0] sel, input int idx);
        if (sel == `SEL_DUAL) begin
            return 1'b1;
        end else if (sel == `SEL_CH0) begin
            return idx == 0;
        end else if (sel == `SEL_CH1) begin
            return idx == 1;
        end else begin
            return 1'b0;
        end
    endfunction : chan_selected

    function automatic logic [31:0] read_mux(input state_t s, input logic [11:0] addr);
        logic [31:0] r;
        r = 32'h0;
        if (addr == `ADDR_CTRL_A) begin
            r = {27'h0, s.ctrl_a};
        end else if (addr == `ADDR_CTRL_B) begin
            r = {25'h0, s.ctrl_b.channel_selection, 3'h0, s.ctrl_b.event_trigger};
        end else if (addr == `ADDR_EVENT_CTRL) begin
            r = {28'h0, s.event_select};
        end else if (addr == `ADDR_STATUS) begin
            r = {30'h0, s.ch[1].slot_empty, s.ch[0].slot_empty};
        end else if (addr == `ADDR_CH0_DATA) begin
            r = {20'h0, s.ch[0].sample};
        end else if (addr == `ADDR_CH1_DATA) begin
            r = {20'h0, s.ch[1].sample};
        end else if (addr == `ADDR_OFFSET_TRIM) begin
            r = {24'h0, s.offset_trim};
        end else if (addr == `ADDR_SLOPE_TRIM) begin
            r = {24'h0, s.slope_trim};
        end
        return r;
    endfunction : read_mux

    function automatic logic addr_mapped(input logic [11:0] addr);
        return addr == `ADDR_CTRL_A || addr == `ADDR_CTRL_B || addr == `ADDR_EVENT_CTRL ||
            addr == `ADDR_STATUS || addr == `ADDR_CH0_DATA || addr == `ADDR_CH1_DATA ||
            addr == `ADDR_OFFSET_TRIM || addr == `ADDR_SLOPE_TRIM;
    endfunction : addr_mapped

    logic access;
    logic commit;
    logic wr;
    logic [1:0] data_wr;
    logic [1:0] ev;
    logic [11:0] conv_len;

    always_comb begin
        access = i_psel && i_penable && !s_q.resp.pready;
        // A write lands only at the edge where the master sees pready high.
        commit = i_psel && i_penable && s_q.resp.pready;
        wr = commit && i_pwrite;
        data_wr[0] = wr && i_paddr == `ADDR_CH0_DATA;
        data_wr[1] = wr && i_paddr == `ADDR_CH1_DATA;
        ev[0] = i_event[s_q.event_select[2:0]];
        ev[1] = s_q.event_select[3] ? i_event[3'(s_q.event_select[2:0] + 3'h1)] : ev[0];
        conv_len = s_q.ctrl_a.reduced_power_select ? 12'(2 * CONV_CYCLES) : 12'(CONV_CYCLES);
        s_d = s_q;
        s_d.resp.pready = access;
        s_d.resp.pslverr = access && !addr_mapped(i_paddr);
        if (access) begin
            s_d.resp.prdata = i_pwrite ? 32'h0 : read_mux(s_q, i_paddr);
        end
        if (wr && i_paddr == `ADDR_CTRL_A) begin
            s_d.ctrl_a = ctrl_a_t'(i_pwdata[4:0]);
        end else if (wr && i_paddr == `ADDR_CTRL_B) begin
            s_d.ctrl_b = {i_pwdata[6:5], i_pwdata[1:0]};
        end else if (wr && i_paddr == `ADDR_EVENT_CTRL) begin
            s_d.event_select = i_pwdata[3:0];
        end else if (wr && i_paddr == `ADDR_OFFSET_TRIM) begin
            s_d.offset_trim = i_pwdata[7:0];
        end else if (wr && i_paddr == `ADDR_SLOPE_TRIM) begin
            s_d.slope_trim = i_pwdata[7:0];
        end
        for (int i = 0; i < 2; i++) begin
            logic go;
            logic active;
            active = s_q.ctrl_a.enable && chan_selected(s_q.ctrl_b.channel_selection, i);
            go = 1'b0;
            if (data_wr[i]) begin
                s_d.ch[i].sample = i_pwdata[11:0];
                s_d.ch[i].updated = 1'b1;
                s_d.ch[i].slot_empty = 1'b0;
            end
            case (s_q.ch[i].state)
                CH_IDLE: begin
                    if (active && s_q.ch[i].updated) begin
                        go = s_q.ctrl_b.event_trigger[i] ? ev[i] : 1'b1;
                    end
                    if (go) begin
                        s_d.ch[i].state = CH_BUSY;
                        s_d.ch[i].held = s_q.ch[i].sample;
                        s_d.ch[i].count = conv_len;
                        s_d.ch[i].updated = data_wr[i];
                        s_d.ch[i].slot_empty = !data_wr[i];
                    end
                end
                CH_BUSY: begin
                    if (!active) begin
                        s_d.ch[i].state = CH_IDLE;
                    end else if (s_q.ch[i].count <= 12'h1) begin
                        s_d.ch[i].state = CH_IDLE;
                    end else begin
                        s_d.ch[i].count = s_q.ch[i].count - 12'h1;
                    end
                end
                default: begin
                    s_d.ch[i].state = CH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.ctrl_a <= ctrl_a_t'(`CTRL_A_RESET);
            s_q.ch[0].state <= CH_IDLE;
            s_q.ch[1].state <= CH_IDLE;
            s_q.ch[0].slot_empty <= 1'b1;
            s_q.ch[1].slot_empty <= 1'b1;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    always_comb begin
        o_prdata = s_q.resp.prdata;
        o_pready = s_q.resp.pready;
        o_pslverr = s_q.resp.pslverr;
        o_ch0_value = s_q.ch[0].held;
        o_ch1_value = s_q.ch[1].held;
        o_conv_busy = {s_q.ch[1].state == CH_BUSY, s_q.ch[0].state == CH_BUSY};
        o_dma_request = {s_q.ch[1].slot_empty, s_q.ch[0].slot_empty};
        o_ch0_pin_enable = s_q.ctrl_a.enable && s_q.ctrl_a.first_channel_pin_enable &&
            !s_q.ctrl_a.internal_route_enable;
        o_ch1_pin_enable = s_q.ctrl_a.enable && s_q.ctrl_a.second_channel_pin_enable;
        o_internal_route = s_q.ctrl_a.enable && s_q.ctrl_a.internal_route_enable;
        o_reduced_power = s_q.ctrl_a.reduced_power_select;
        o_offset_trim_value = s_q.offset_trim;
        o_slope_trim_value = s_q.slope_trim;
    end

    a_pin_zero_route: assert property (@(posedge i_clk) disable iff (i_reset)
        o_internal_route |-> !o_ch0_pin_enable) else $error("pin driven while routed inside");
    a_ctrl_upper_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_pready && !i_pwrite && i_paddr == `ADDR_CTRL_A) |-> o_prdata[7:5] == 3'h0)
        else $error("control upper bits not zero");
    a_auto_start: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && s_q.ch[0].state == CH_IDLE && s_q.ch[0].updated && s_q.ctrl_a.enable &&
        chan_selected(s_q.ctrl_b.channel_selection, 0) && !s_q.ctrl_b.event_trigger[0])
        |=> o_conv_busy[0]) else $error("auto start missed");
    a_event_wait: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.ch[0].state == CH_IDLE && s_q.ctrl_b.event_trigger[0] && !ev[0])
        |=> !o_conv_busy[0]) else $error("start without event");
    a_no_update_no_start: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.ch[1].state == CH_IDLE && !s_q.ch[1].updated) |=> !o_conv_busy[1])
        else $error("start without new data");
    a_disabled_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        (!s_q.ctrl_a.enable && !o_conv_busy[0]) |=> !o_conv_busy[0]) else $error("start while disabled");
    a_select_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.ctrl_b.channel_selection == `SEL_CH1 && !o_conv_busy[0]) |=> !o_conv_busy[0])
        else $error("unselected channel started");
    a_dma_follows: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && data_wr[1]) |=> !o_dma_request[1]) else $error("slot not filled");
    a_pin_one: assert property (@(posedge i_clk) disable iff (i_reset)
        o_ch1_pin_enable |-> (s_q.ctrl_a.second_channel_pin_enable && s_q.ctrl_a.enable))
        else $error("channel 1 pin without enable");
    a_long_conv: assert property (@(posedge i_clk) disable iff (i_reset)
        ($rose(o_conv_busy[0]) && o_reduced_power) |-> s_q.ch[0].count == 12'(2 * CONV_CYCLES))
        else $error("reduced power length wrong");
    c_auto: cover property (@(posedge i_clk) $rose(o_conv_busy[0]));
    c_event: cover property (@(posedge i_clk) $rose(o_conv_busy[1]) && s_q.ctrl_b.event_trigger[1]);
    c_dual: cover property (@(posedge i_clk) o_conv_busy == 2'h3);
endmodule : dac_ctl

// *** bench/dac_load_model.sv ***
// Purpose: Load model at the two analog pins and at the internal comparator input.
// Assumes: Codes stand for voltages; an undriven pin shows the inverse of its last level.
// Notes: None.
`timescale 1ns/1ps
module dac_load_model (
    input wire logic i_clk,
    input wire logic [11:0] i_ch0_value,
    input wire logic [11:0] i_ch1_value,
    input wire logic i_ch0_pin_enable,
    input wire logic i_ch1_pin_enable,
    input wire logic i_internal_route,
    output logic [11:0] o_pin0_level,
    output logic [11:0] o_pin1_level,
    output logic [11:0] o_internal_level
);
    logic [11:0] last0_q = 12'h000;
    logic [11:0] last1_q = 12'h000;
    always_ff @(posedge i_clk) begin
        last0_q <= o_pin0_level;
        last1_q <= o_pin1_level;
    end
    // A pin or the internal input follows its channel only while driven.
    assign o_pin0_level = i_ch0_pin_enable ? i_ch0_value : ~last0_q;
    assign o_pin1_level = i_ch1_pin_enable ? i_ch1_value : ~last1_q;
    assign o_internal_level = i_internal_route ? i_ch0_value : ~i_ch0_value;
endmodule : dac_load_model

// *** bench/dual_channel_dac_control_tb.sv ***
// Purpose: Self-checking bench of the dual channel converter control.
// Assumes: Short conversion count; clock enable held high.
// Notes: Random codes come from a fixed-seed shift register.
`timescale 1ns/1ps
`include "dac_ctl_consts.svh"
module dual_channel_dac_control_tb;
    import dac_ctl_pkg::*;
    localparam int CC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [7:0] ev = 8'h00;
    logic [31:0] prd, rd, seed = 32'hc859;
    logic pready, pslverr, er, p0e, p1e, irt, rpw;
    logic [11:0] v0, v1, pin0, pin1, intl;
    logic [1:0] busy, dma;
    logic [7:0] otr, str;
    int error_cnt = 0, cmp_count = 0, n;
    int bc[2] = '{0, 0};
    always #10 clk = ~clk;
    always @(posedge clk) begin
        bc[0] <= bc[0] + int'(busy[0]);
        bc[1] <= bc[1] + int'(busy[1]);
    end
    dac_ctl #(.CONV_CYCLES(CC)) i_dut (
        .i_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .i_event(ev), .o_prdata(prd), .o_pready(pready),
        .o_pslverr(pslverr), .o_ch0_value(v0), .o_ch1_value(v1), .o_conv_busy(busy),
        .o_dma_request(dma), .o_ch0_pin_enable(p0e), .o_ch1_pin_enable(p1e),
        .o_internal_route(irt), .o_reduced_power(rpw), .o_offset_trim_value(otr),
        .o_slope_trim_value(str)
    );
    dac_load_model i_load (
        .i_clk(clk), .i_ch0_value(v0), .i_ch1_value(v1), .i_ch0_pin_enable(p0e),
        .i_ch1_pin_enable(p1e), .i_internal_route(irt), .o_pin0_level(pin0),
        .o_pin1_level(pin1), .o_internal_level(intl)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) chk(32'h1, 32'h0);
        rd = prd;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(negedge clk);
    endtask : apb
    // Counts busy cycles of both channels over a window spanning optional data writes or an event pulse and the 24 cycles after.
    task automatic run(input logic [11:0] d0, input logic [11:0] d1, input logic [7:0] e, input logic wr,
                       input int e0, input int e1);
        int b0, b1;
        b0 = bc[0];
        b1 = bc[1];
        if (wr) apb(1'b1, `ADDR_CH0_DATA, {20'h0, d0});
        if (wr) apb(1'b1, `ADDR_CH1_DATA, {20'h0, d1});
        if (e != 8'h00) begin
            @(posedge clk);
            ev <= e;
            @(posedge clk);
            ev <= 8'h00;
        end
        repeat (24) @(posedge clk);
        chk(bc[0] - b0, e0);
        chk(bc[1] - b1, e1);
    endtask : run
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(dma, 2'b11);
        apb(1'b0, `ADDR_CTRL_A, 32'h0);
        chk(rd, 32'h0);
        chk({p0e, p1e, irt, rpw}, 32'h0);
        $display("Test reset done");
        for (int v = 0; v < 32; v++) begin
            apb(1'b1, `ADDR_CTRL_A, v);
            apb(1'b0, `ADDR_CTRL_A, 32'h0);
            chk(rd, v);
            chk({p0e, p1e, irt, rpw}, {v[2] & ~v[4] & v[0], v[3] & v[0], v[4] & v[0], v[1]});
        end
        apb(1'b1, `ADDR_CTRL_A, 32'hff);
        apb(1'b0, `ADDR_CTRL_A, 32'h0);
        chk(rd, 32'h1f);
        apb(1'b0, 12'h008, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        seed = lfsr(seed);
        apb(1'b1, `ADDR_OFFSET_TRIM, {24'h0, seed[7:0]});
        apb(1'b1, `ADDR_SLOPE_TRIM, {24'h0, seed[15:8]});
        chk({otr, str}, {seed[7:0], seed[15:8]});
        apb(1'b0, `ADDR_OFFSET_TRIM, 32'h0);
        chk(rd, seed[7:0]);
        $display("Test registers done");
        for (int s = 0; s < 3; s++) begin
            for (int e = 0; e < 3; e++) begin
                apb(1'b1, `ADDR_CTRL_A, (e == 0) ? 0 : e * 2 - 1);
                apb(1'b1, `ADDR_CTRL_B, s << 5);
                repeat (24) @(posedge clk);
                seed = lfsr(seed);
                n = (e == 0) ? 0 : CC * e;
                run(seed[11:0], seed[27:16], 8'h00, 1'b1, (s != 1) ? n : 0, (s != 0) ? n : 0);
                if (n > 0 && s != 1) chk(v0, seed[11:0]);
                if (n > 0 && s != 0) chk(v1, seed[27:16]);
                chk(dma, {n > 0 && s != 0, n > 0 && s != 1});
            end
        end
        apb(1'b1, `ADDR_CTRL_A, 32'h0d);
        chk({pin0, pin1}, {seed[11:0], seed[27:16]});
        apb(1'b1, `ADDR_CTRL_A, 32'h1d);
        chk({p0e, intl}, {1'b0, seed[11:0]});
        $display("Test selection done");
        apb(1'b1, `ADDR_CTRL_A, 32'h1);
        apb(1'b1, `ADDR_CTRL_B, 32'h43);
        apb(1'b1, `ADDR_EVENT_CTRL, 32'hb);
        seed = lfsr(seed);
        run(seed[11:0], seed[27:16], 8'h00, 1'b1, 0, 0);
        run(12'h0, 12'h0, 8'h08, 1'b0, CC, 0);
        run(12'h0, 12'h0, 8'h10, 1'b0, 0, CC);
        run(12'h0, 12'h0, 8'h08, 1'b0, 0, 0);
        chk({v0, v1}, {seed[11:0], seed[27:16]});
        $display("Test events done");
        apb(1'b1, `ADDR_CTRL_B, 32'h0);
        run(12'h800, 12'h000, 8'h00, 1'b1, CC, 0);
        chk(v0, 12'h800);
        apb(1'b1, `ADDR_SLOPE_TRIM, 32'h81);
        run(12'hfff, 12'h000, 8'h00, 1'b1, CC, 0);
        chk({v0, str}, {12'hfff, 8'h81});
        $display("Test trim done");
        end_of_test();
    end
endmodule : dual_channel_dac_control_tb
